//--- charger_opt_pkg.sv
// constants shared by the charger option bank and its smbus slave
package charger_opt_pkg;
   // command codes of the registers held here
   localparam logic [7:0] REG_OPT0 = 8'h12;
   localparam logic [7:0] REG_OPT1 = 8'h3B;
   localparam logic [7:0] REG_ICHG = 8'h14;
   localparam logic [7:0] REG_VCHG = 8'h15;
   // reset values and writable-bit masks
   localparam logic [15:0] OPT0_RST = 16'hE108;
   localparam logic [15:0] OPT1_RST = 16'hC210;
   localparam logic [15:0] SET_RST = 16'h0000;
   localparam logic [15:0] OPT0_MASK = 16'hE339;
   localparam logic [15:0] OPT1_MASK = 16'hFEFA;
   localparam logic [15:0] ICHG_MASK = 16'h1FC0;
   localparam logic [15:0] VCHG_MASK = 16'h7FF0;
   localparam logic [15:0] OPT0_LEARN_M = 16'h0020;
   localparam logic [15:0] READ_NONE = 16'h0000;
   // field positions of the primary option word
   localparam int OPT0_LWPWR = 15;
   localparam int OPT0_WDT_LO = 13;
   localparam int OPT0_RATE_LO = 8;
   localparam int OPT0_LEARN = 5;
   localparam int OPT0_ADPG = 4;
   localparam int OPT0_DCHG = 3;
   localparam int OPT0_INHIB = 0;
   // field positions of the secondary option word and the charge-current and charge-voltage settings
   localparam int OPT1_EN_DISCHARGE_CURRENT_MONITOR = 11;
   localparam int OPT1_EN_POWER_MONITOR = 10;
   localparam int OPT1_CMPDEG_LO = 4;
   localparam int ICHG_LO = 6;
   localparam int VCHG_LO = 4;
   // field codes
   localparam logic [1:0] WDT_OFF = 2'h0;
   localparam logic [1:0] WDT_SHORT = 2'h1;
   localparam logic [1:0] WDT_MID = 2'h2;
   localparam logic [1:0] WDT_LONG = 2'h3;
   localparam logic [1:0] RATE_RSVD = 2'h3;
   localparam logic [1:0] CMP_OFF = 2'h0;
   // watchdog periods in seconds and in sys_clk cycles
   localparam longint CLK_HZ = 125_000_000;
   localparam longint WDT_SHORT_S = 5;
   localparam longint WDT_MID_S = 88;
   localparam longint WDT_LONG_S = 175;
   localparam longint WDT_SHORT_CYC = WDT_SHORT_S * CLK_HZ;
   localparam longint WDT_MID_CYC = WDT_MID_S * CLK_HZ;
   localparam longint WDT_LONG_CYC = WDT_LONG_S * CLK_HZ;
   localparam int WDT_W = 36;
   // bus address, arbitrary value
   localparam logic [6:0] SLAVE_ADDR_DEF = 7'h09;
endpackage

//--- smbus_word_slave.sv
// smbus slave for write-word and read-word transactions
`timescale 1ns/100ps
module smbus_word_slave
   import charger_opt_pkg::*;
#(
   parameter logic [6:0] SLAVE_ADDR = SLAVE_ADDR_DEF
)(
   // clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic clkEn,
   // bus pins, asynchronous
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOe,
   // register side
   output logic [7:0] cmd,
   output logic wrStb,
   output logic [15:0] wrData,
   input wire logic [15:0] rdData
);
   typedef enum logic [4:0] {
      S_IDLE = 5'b00001,
      S_RX = 5'b00010,
      S_ACK = 5'b00100,
      S_TX = 5'b01000,
      S_MACK = 5'b10000
   } slv_state_e;

   slv_state_e state_r;
   logic sclMeta_r, sclSync_r, sclPrev_r, sdaMeta_r, sdaSync_r, sdaPrev_r;
   logic [3:0] bitCnt_r;
   logic [7:0] shift_r, hold_r, tx_r, cmd_r;
   logic [1:0] byteNum_r;
   logic readMode_r, sdaOe_r, wrStb_r;
   logic [15:0] wrData_r;

   // edges and bus conditions seen on the synchronised lines
   wire sclRise = sclSync_r & ~sclPrev_r;
   wire sclFall = ~sclSync_r & sclPrev_r;
   wire startCond = sclSync_r & sclPrev_r & sdaPrev_r & ~sdaSync_r;
   wire stopCond = sclSync_r & sclPrev_r & ~sdaPrev_r & sdaSync_r;
   wire byteDone = sclFall & (bitCnt_r == 4'h8);
   wire addrHit = shift_r[7:1] == SLAVE_ADDR;

   assign sdaOe = sdaOe_r;
   assign cmd = cmd_r;
   assign wrStb = wrStb_r;
   assign wrData = wrData_r;

   // two-flop synchronisers plus one history stage for edge detection
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         {sclMeta_r, sclSync_r, sclPrev_r} <= 3'h7;
         {sdaMeta_r, sdaSync_r, sdaPrev_r} <= 3'h7;
      end else if (clkEn) begin
         {sclMeta_r, sclSync_r, sclPrev_r} <= {sclIn, sclMeta_r, sclSync_r};
         {sdaMeta_r, sdaSync_r, sdaPrev_r} <= {sdaIn, sdaMeta_r, sdaSync_r};
      end
   end

   // byte engine; a start anywhere restarts the frame, a stop drops it
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state_r <= S_IDLE;
         bitCnt_r <= 4'h0;
         shift_r <= 8'h00;
         hold_r <= 8'h00;
         tx_r <= 8'h00;
         cmd_r <= 8'h00;
         byteNum_r <= 2'h0;
         readMode_r <= 1'b0;
         sdaOe_r <= 1'b0;
         wrStb_r <= 1'b0;
         wrData_r <= 16'h0000;
      end else if (clkEn) begin
         wrStb_r <= 1'b0;
         if (startCond) begin
            state_r <= S_RX;
            bitCnt_r <= 4'h0;
            byteNum_r <= 2'h0;
            sdaOe_r <= 1'b0;
         end else if (stopCond) begin
            state_r <= S_IDLE;
            sdaOe_r <= 1'b0;
         end else begin
            unique case (state_r)
               S_IDLE: begin
               end
               S_RX: begin
                  if (sclRise) begin
                     shift_r <= {shift_r[6:0], sdaSync_r};
                     bitCnt_r <= bitCnt_r + 4'h1;
                  end else if (byteDone) begin
                     sdaOe_r <= (byteNum_r != 2'h0) | addrHit;
                     state_r <= ((byteNum_r != 2'h0) | addrHit) ? S_ACK : S_IDLE;
                     if (byteNum_r == 2'h0) readMode_r <= shift_r[0];
                     if (byteNum_r == 2'h1) cmd_r <= shift_r;
                     if (byteNum_r == 2'h2) hold_r <= shift_r;
                     // low byte first, high byte completes the word
                     if (byteNum_r == 2'h3) begin
                        wrData_r <= {shift_r, hold_r};
                        wrStb_r <= 1'b1;
                     end
                  end
               end
               S_ACK: begin
                  if (sclFall) begin
                     if (readMode_r) begin
                        // whole word latched now so both bytes match
                        tx_r <= rdData[7:0];
                        hold_r <= rdData[15:8];
                        sdaOe_r <= ~rdData[7];
                        bitCnt_r <= 4'h1;
                        byteNum_r <= 2'h2;
                        state_r <= S_TX;
                     end else begin
                        sdaOe_r <= 1'b0;
                        bitCnt_r <= 4'h0;
                        byteNum_r <= byteNum_r + 2'h1;
                        state_r <= (byteNum_r == 2'h3) ? S_IDLE : S_RX;
                     end
                  end
               end
               S_TX: begin
                  if (byteDone) begin
                     sdaOe_r <= 1'b0;
                     state_r <= S_MACK;
                  end else if (sclFall) begin
                     sdaOe_r <= ~tx_r[6];
                     tx_r <= {tx_r[6:0], 1'b0};
                     bitCnt_r <= bitCnt_r + 4'h1;
                  end
               end
               S_MACK: begin
                  if (sclRise) begin
                     shift_r[0] <= sdaSync_r;
                  end else if (sclFall) begin
                     if (!shift_r[0] && byteNum_r == 2'h2) begin
                        tx_r <= hold_r;
                        sdaOe_r <= ~hold_r[7];
                        bitCnt_r <= 4'h1;
                        byteNum_r <= 2'h3;
                        state_r <= S_TX;
                     end else begin
                        state_r <= S_IDLE;
                     end
                  end
               end
               default: state_r <= S_IDLE;
            endcase
         end
      end
   end
endmodule

//--- charger_option_control_bank.sv
// charger option registers, watchdog, learn mode and power-path control
//
// Function
// - Low-power select at 1 on battery only turns off the hot alert, both monitor buffers and the comparator.
// - Low-power select at 0 on battery only keeps the hot alert on and lets the monitors and comparator follow their own settings.
// - An enabled watchdog that sees no current or voltage write within its period stops charge and boost.
// - After expiry a current or voltage write restarts the timer and lets charge or boost resume.
// - Watchdog code 00 disables it, 01 is 5 s, 10 is 88 s, 11 is 175 s and is the reset value.
// - Switching-rate code 00 is 600 kHz, 01 is 800 kHz by default, 10 is 1 MHz, 11 is reserved.
// - Learn enable turns the adapter and reverse-block switches off and the battery switch on.
// - Battery-present-low going high during learn ends learn mode and clears the enable bit.
// - A depleted battery keeps learn mode from being entered even when the bit is written.
// - Adapter sense gain bit selects 20X at 0 and 40X at 1.
// - Discharge sense gain bit selects 8x at 0 and 16x at 1, the reset value.
// - Charge block at 0 allows charging with valid current and voltage settings, at 1 it inhibits charging.
// - The primary option word resets to E108 and is readable and writable.
// - The charge-current and charge-voltage settings reset to zero and their writes service the watchdog.
`timescale 1ns/100ps
module charger_option_control_bank
   import charger_opt_pkg::*;
#(
   parameter logic [6:0] SLAVE_ADDR = SLAVE_ADDR_DEF,
   parameter logic [WDT_W-1:0] WDT_SHORT_CYCLES = WDT_W'(WDT_SHORT_CYC),
   parameter logic [WDT_W-1:0] WDT_MID_CYCLES = WDT_W'(WDT_MID_CYC),
   parameter logic [WDT_W-1:0] WDT_LONG_CYCLES = WDT_W'(WDT_LONG_CYC)
)(
   // clock, reset, enable
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic clkEn,
   // smbus pins
   input wire logic smbClkIn,
   input wire logic smbDataIn,
   output logic smbDataOut,
   output logic smbDataOe,
   // supply status pins
   input wire logic battery_present_n,
   input wire logic batteryOnly,
   input wire logic batteryDepleted,
   // other enabling conditions from same-clock logic
   input wire logic chargeConditionsOk,
   // mode and monitor controls
   output logic lowPowerActive,
   output logic processorHotAlertEn,
   output logic dischargeMonitorEn,
   output logic powerMonitorEn,
   output logic comparatorEn,
   output logic [1:0] switchRateSel,
   output logic adapterSenseGainSel,
   output logic dischargeSenseGainSel,
   // power path
   output logic adapterSwitchOn,
   output logic reverseBlockSwitchOn,
   output logic batterySwitchOn,
   output logic learnActive,
   // converter
   output logic chargeEnable,
   output logic converterEnable,
   output logic watchdogExpired,
   output logic [6:0] chargeCurrentSet,
   output logic [10:0] chargeVoltageSet
);
   logic [15:0] opt0_r, opt1_r, ichg_r, vchg_r;
   logic [2:0] pinMeta_r, pinSync_r;
   logic [WDT_W-1:0] wdtCnt_r;
   logic wdtExp_r, dataOut_r;
   logic lowPwr_r, hotEn_r, dchgMon_r, pwrMon_r, cmpEn_r, adpG_r, dchgG_r;
   logic adpSw_r, rbSw_r, batSw_r, learn_r, chgEn_r, convEn_r;
   logic [1:0] rate_r;
   logic [6:0] ichgOut_r;
   logic [10:0] vchgOut_r;
   logic [7:0] cmd;
   logic wrStb, sdaOeSlv;
   logic [15:0] wrData, rdData;

   // period code to cycle count
   function automatic logic [WDT_W-1:0] wdtLimit(input logic [1:0] sel);
      logic [WDT_W-1:0] lim;
      lim = WDT_LONG_CYCLES;
      if (sel == WDT_SHORT) lim = WDT_SHORT_CYCLES;
      if (sel == WDT_MID) lim = WDT_MID_CYCLES;
      return lim;
   endfunction

   smbus_word_slave #(
      .SLAVE_ADDR(SLAVE_ADDR)
   ) i_smbus_word_slave (
      .sys_clk(sys_clk),
      .srst(srst),
      .clkEn(clkEn),
      .sclIn(smbClkIn),
      .sdaIn(smbDataIn),
      .sdaOe(sdaOeSlv),
      .cmd(cmd),
      .wrStb(wrStb),
      .wrData(wrData),
      .rdData(rdData)
   );

   // synchronised status pins
   wire batPresNs = pinSync_r[0];
   wire battOnlyS = pinSync_r[1];
   wire depletedS = pinSync_r[2];

   // write decode and read select
   wire wrOpt0 = wrStb & (cmd == REG_OPT0);
   wire wrOpt1 = wrStb & (cmd == REG_OPT1);
   wire wrIchg = wrStb & (cmd == REG_ICHG);
   wire wrVchg = wrStb & (cmd == REG_VCHG);
   wire svcWr = wrIchg | wrVchg;
   assign rdData = (cmd == REG_OPT0) ? opt0_r :
                   (cmd == REG_OPT1) ? opt1_r :
                   (cmd == REG_ICHG) ? ichg_r :
                   (cmd == REG_VCHG) ? vchg_r : READ_NONE;

   // primary word update; reserved rate code keeps the old rate
   wire [15:0] opt0Wr = wrData & OPT0_MASK;
   wire keepRate = opt0Wr[OPT0_RATE_LO+:2] == RATE_RSVD;
   wire [1:0] rateNew = keepRate ? opt0_r[OPT0_RATE_LO+:2] : opt0Wr[OPT0_RATE_LO+:2];
   wire [15:0] opt0Sel = wrOpt0 ? {opt0Wr[15:10], rateNew, opt0Wr[7:0]} : opt0_r;
   // presence loss or depletion clears learn; this hardware clear beats a same-cycle write
   wire learnClr = batPresNs | depletedS;
   wire [15:0] opt0_nxt = learnClr ? (opt0Sel & ~OPT0_LEARN_M) : opt0Sel;
   wire [1:0] wdtSel = opt0_r[OPT0_WDT_LO+:2];
   wire perChg = opt0_nxt[OPT0_WDT_LO+:2] != wdtSel;
   wire wdtHit = wdtCnt_r == (wdtLimit(wdtSel) - WDT_W'(1));

   // output next values
   wire lowPwr = opt0_r[OPT0_LWPWR] & battOnlyS;
   wire learnOn = opt0_r[OPT0_LEARN];
   wire cmpCfgOn = opt1_r[OPT1_CMPDEG_LO+:2] != CMP_OFF;
   wire setsValid = (ichg_r != SET_RST) & (vchg_r != SET_RST);
   wire chgEn_nxt = ~opt0_r[OPT0_INHIB] & setsValid & ~wdtExp_r & ~learnOn & chargeConditionsOk;

   // registers and pin synchronisers; reset wins over the enable
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         opt0_r <= OPT0_RST;
         opt1_r <= OPT1_RST;
         ichg_r <= SET_RST;
         vchg_r <= SET_RST;
         pinMeta_r <= 3'h1;
         pinSync_r <= 3'h1;
      end else if (clkEn) begin
         pinMeta_r <= {batteryDepleted, batteryOnly, battery_present_n};
         pinSync_r <= pinMeta_r;
         opt0_r <= opt0_nxt;
         if (wrOpt1) opt1_r <= wrData & OPT1_MASK;
         if (wrIchg) ichg_r <= wrData & ICHG_MASK;
         if (wrVchg) vchg_r <= wrData & VCHG_MASK;
      end
   end

   // watchdog: a service write clears expiry, a period change only restarts the count
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         wdtCnt_r <= '0;
         wdtExp_r <= 1'b0;
      end else if (clkEn) begin
         if (svcWr || perChg || wdtSel == WDT_OFF) begin
            wdtCnt_r <= '0;
         end else if (!wdtExp_r) begin
            wdtCnt_r <= wdtCnt_r + WDT_W'(1);
         end
         if (svcWr || wdtSel == WDT_OFF) begin
            wdtExp_r <= 1'b0;
         end else if (!perChg && !wdtExp_r && wdtHit) begin
            wdtExp_r <= 1'b1;
         end
      end
   end

   // registered outputs
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         {lowPwr_r, hotEn_r, dchgMon_r, pwrMon_r, cmpEn_r} <= 5'h00;
         {adpG_r, dchgG_r, adpSw_r, rbSw_r, batSw_r, learn_r} <= 6'h00;
         {chgEn_r, convEn_r, dataOut_r} <= 3'h0;
         rate_r <= OPT0_RST[OPT0_RATE_LO+:2];
         ichgOut_r <= 7'h00;
         vchgOut_r <= 11'h000;
      end else if (clkEn) begin
         lowPwr_r <= lowPwr;
         hotEn_r <= ~lowPwr;
         dchgMon_r <= ~lowPwr & opt1_r[OPT1_EN_DISCHARGE_CURRENT_MONITOR];
         pwrMon_r <= ~lowPwr & opt1_r[OPT1_EN_POWER_MONITOR];
         cmpEn_r <= ~lowPwr & cmpCfgOn;
         rate_r <= opt0_r[OPT0_RATE_LO+:2];
         adpG_r <= opt0_r[OPT0_ADPG];
         dchgG_r <= opt0_r[OPT0_DCHG];
         adpSw_r <= ~learnOn;
         rbSw_r <= ~learnOn;
         batSw_r <= learnOn | battOnlyS;
         learn_r <= learnOn;
         chgEn_r <= chgEn_nxt;
         convEn_r <= ~wdtExp_r;
         ichgOut_r <= ichg_r[ICHG_LO+:7];
         vchgOut_r <= vchg_r[VCHG_LO+:11];
         dataOut_r <= 1'b0;
      end
   end

   assign smbDataOut = dataOut_r;
   assign smbDataOe = sdaOeSlv;
   assign lowPowerActive = lowPwr_r;
   assign processorHotAlertEn = hotEn_r;
   assign dischargeMonitorEn = dchgMon_r;
   assign powerMonitorEn = pwrMon_r;
   assign comparatorEn = cmpEn_r;
   assign switchRateSel = rate_r;
   assign adapterSenseGainSel = adpG_r;
   assign dischargeSenseGainSel = dchgG_r;
   assign adapterSwitchOn = adpSw_r;
   assign reverseBlockSwitchOn = rbSw_r;
   assign batterySwitchOn = batSw_r;
   assign learnActive = learn_r;
   assign chargeEnable = chgEn_r;
   assign converterEnable = convEn_r;
   assign watchdogExpired = wdtExp_r;
   assign chargeCurrentSet = ichgOut_r;
   assign chargeVoltageSet = vchgOut_r;

   // checks on the control behaviour
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   chk_lowpwr_off: assert property (clkEn && opt0_r[OPT0_LWPWR] && battOnlyS |=>
      !hotEn_r && !dchgMon_r && !pwrMon_r && !cmpEn_r) else $error("monitors on in low power");
   chk_perf_follow: assert property (clkEn && !opt0_r[OPT0_LWPWR] |=>
      pwrMon_r == $past(opt1_r[OPT1_EN_POWER_MONITOR]) && hotEn_r) else $error("monitor ignores setting");
   chk_wdt_stop: assert property (clkEn && wdtExp_r |=> !convEn_r) else $error("converter on after expiry");
   chk_wdt_service: assert property (clkEn && svcWr |=> wdtCnt_r == '0 && !wdtExp_r)
      else $error("service write did not restart");
   chk_wdt_period: assert property (clkEn && !wdtExp_r && wdtHit && !svcWr && !perChg && wdtSel != WDT_OFF
      |=> wdtExp_r) else $error("watchdog missed its period");
   chk_wdt_restart: assert property (clkEn && perChg && !svcWr |=> wdtCnt_r == '0)
      else $error("period change did not restart");
   chk_rate_hold: assert property (clkEn && wrOpt0 && wrData[OPT0_RATE_LO+:2] == RATE_RSVD
      |=> $stable(opt0_r[OPT0_RATE_LO+:2])) else $error("reserved rate code taken");
   chk_learn_path: assert property (clkEn && learnOn |=> !adpSw_r && !rbSw_r && batSw_r)
      else $error("learn power path wrong");
   chk_learn_exit: assert property (clkEn && learnOn && batPresNs |=> !opt0_r[OPT0_LEARN])
      else $error("learn not left on battery removal");
   chk_learn_refuse: assert property (clkEn && depletedS |=> !opt0_r[OPT0_LEARN])
      else $error("learn entered while depleted");
   chk_gain_sel: assert property (clkEn |=> adpG_r == $past(opt0_r[OPT0_ADPG])
      && dchgG_r == $past(opt0_r[OPT0_DCHG])) else $error("gain select mismatch");
   chk_charge_block: assert property (clkEn && (opt0_r[OPT0_INHIB] || !setsValid) |=> !chgEn_r)
      else $error("charging while blocked");
   chk_reset_vals: assert property (disable iff (1'b0) srst |=> opt0_r == OPT0_RST
      && ichg_r == SET_RST && vchg_r == SET_RST) else $error("bad reset value");
   chk_reserved_zero: assert property ((opt0_r & ~OPT0_MASK) == 16'h0000
      && (opt1_r & ~OPT1_MASK) == 16'h0000) else $error("reserved bit set");

   cov_wdt_expire: cover property (clkEn && !wdtExp_r ##1 wdtExp_r);
   cov_learn_exit: cover property (learnOn ##1 !learnOn);
   cov_charge_on: cover property (!chgEn_r ##1 chgEn_r);
   cov_opt0_write: cover property (wrOpt0);
endmodule

//--- smbus_host_model.sv
// smbus host model issuing write-word and read-word frames
`timescale 1ns/100ps
module smbus_host_model
   import charger_opt_pkg::*;
#(
   parameter int HALF = 10
)(
   // clock
   input wire logic sys_clk,
   // bus lines, data is open drain with a pull-up
   output logic scl,
   output logic sdaPullLow,
   input wire logic sdaLine
);
   logic ackSeen;
   initial begin
      scl = 1'b1;
      sdaPullLow = 1'b0;
   end
   // one clock phase; changes land just after an edge, never on it
   task automatic phase();
      repeat (HALF) @(posedge sys_clk);
      #1;
   endtask
   // data set while the clock is low, sampled at the end of the high phase
   task automatic bit_io(input logic b, output logic s);
      sdaPullLow = ~b;
      phase();
      scl = 1'b1;
      phase();
      s = sdaLine;
      scl = 1'b0;
   endtask
   // eight bits msb first, then the ninth clock; ackOut 1 releases the line
   task automatic byte_io(input logic [7:0] tx, input logic ackOut, output logic [7:0] rx);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], s);
         rx[i] = s;
      end
      bit_io(ackOut, ackSeen);
   endtask
   // start from idle, or repeated start while the clock is low
   task automatic start();
      sdaPullLow = 1'b0;
      phase();
      scl = 1'b1;
      phase();
      sdaPullLow = 1'b1;
      phase();
      scl = 1'b0;
   endtask
   task automatic stop();
      sdaPullLow = 1'b1;
      phase();
      scl = 1'b1;
      phase();
      sdaPullLow = 1'b0;
      phase();
   endtask
   // command, low byte, then high byte
   task automatic write_word(input logic [7:0] cmd, input logic [15:0] data);
      logic [7:0] rx;
      start();
      byte_io({SLAVE_ADDR_DEF, 1'b0}, 1'b1, rx);
      byte_io(cmd, 1'b1, rx);
      byte_io(data[7:0], 1'b1, rx);
      byte_io(data[15:8], 1'b1, rx);
      stop();
   endtask
   // low byte acked by the host, high byte refused to end the read
   task automatic read_word(input logic [7:0] cmd, output logic [15:0] data);
      logic [7:0] rx;
      start();
      byte_io({SLAVE_ADDR_DEF, 1'b0}, 1'b1, rx);
      byte_io(cmd, 1'b1, rx);
      start();
      byte_io({SLAVE_ADDR_DEF, 1'b1}, 1'b1, rx);
      byte_io(8'hFF, 1'b0, data[7:0]);
      byte_io(8'hFF, 1'b1, data[15:8]);
      stop();
   endtask
endmodule

//--- tb_charger_option_control_bank.sv
// self-checking bench for the charger option bank over its smbus port
`timescale 1ns/100ps
module tb_charger_option_control_bank import charger_opt_pkg::*;;
   logic sys_clk = 1'b0, srst = 1'b1, battery_present_n = 1'b0, batteryOnly = 1'b0;
   logic batteryDepleted = 1'b0, chargeConditionsOk = 1'b1, clkEn = 1'b1, scl, sdaPullLow, smbDataOe, smbDataOut;
   logic lowPowerActive, processorHotAlertEn, dischargeMonitorEn, powerMonitorEn, comparatorEn;
   logic adapterSenseGainSel, dischargeSenseGainSel, adapterSwitchOn, reverseBlockSwitchOn;
   logic batterySwitchOn, learnActive, chargeEnable, converterEnable, watchdogExpired;
   logic [1:0] switchRateSel;
   logic [6:0] chargeCurrentSet;
   logic [10:0] chargeVoltageSet;
   int err_count = 0, comparisons = 0;
   // wired-and data line with pull-up
   wire sdaLine = ~sdaPullLow & (smbDataOe ? smbDataOut : 1'b1);
   initial begin
      forever #4 sys_clk = ~sys_clk;
   end
   // short watchdog counts keep the timer scenarios brief
   charger_option_control_bank #(.WDT_SHORT_CYCLES(36'h14), .WDT_MID_CYCLES(36'h28),
      .WDT_LONG_CYCLES(36'h50)) i_charger_option_control_bank (.sys_clk(sys_clk), .srst(srst),
      .clkEn(clkEn), .smbClkIn(scl), .smbDataIn(sdaLine), .smbDataOut(smbDataOut), .smbDataOe(smbDataOe),
      .battery_present_n(battery_present_n), .batteryOnly(batteryOnly), .batteryDepleted(batteryDepleted),
      .chargeConditionsOk(chargeConditionsOk), .lowPowerActive(lowPowerActive),
      .processorHotAlertEn(processorHotAlertEn), .dischargeMonitorEn(dischargeMonitorEn),
      .powerMonitorEn(powerMonitorEn), .comparatorEn(comparatorEn), .switchRateSel(switchRateSel),
      .adapterSenseGainSel(adapterSenseGainSel), .dischargeSenseGainSel(dischargeSenseGainSel),
      .adapterSwitchOn(adapterSwitchOn), .reverseBlockSwitchOn(reverseBlockSwitchOn),
      .batterySwitchOn(batterySwitchOn), .learnActive(learnActive), .chargeEnable(chargeEnable),
      .converterEnable(converterEnable), .watchdogExpired(watchdogExpired),
      .chargeCurrentSet(chargeCurrentSet), .chargeVoltageSet(chargeVoltageSet));
   smbus_host_model i_smbus_host_model (.sys_clk(sys_clk), .scl(scl), .sdaPullLow(sdaPullLow),
      .sdaLine(sdaLine));
   task automatic finish_test();
      if (err_count == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // registered outputs lag the write strobe by two cycles
   task automatic settle();
      repeat (4) @(posedge sys_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      i_smbus_host_model.write_word(c, d);
      settle();
   endtask
   task automatic rd_chk(input logic [7:0] c, input logic [15:0] exp);
      logic [15:0] v;
      i_smbus_host_model.read_word(c, v);
      check(32'(v), 32'(exp));
   endtask
   // a hang is cut short well past the longest expected run
   initial begin
      repeat (80000) @(posedge sys_clk);
      err_count++;
      finish_test();
   end
   initial begin
      repeat (16) @(posedge sys_clk);
      #1 srst = 1'b0;
      settle();
      check(32'({switchRateSel, adapterSenseGainSel, dischargeSenseGainSel, learnActive, adapterSwitchOn,
         converterEnable}), 32'h2B);
      rd_chk(REG_OPT0, 16'hE108);
      rd_chk(REG_ICHG, 16'h0000);
      rd_chk(REG_VCHG, 16'h0000);
      // all ones: reserved bits dropped, rate 11 keeps 800 kHz, learn taken
      wr(REG_OPT0, 16'hFFFF);
      check(32'({learnActive, adapterSwitchOn, reverseBlockSwitchOn, batterySwitchOn, adapterSenseGainSel,
         switchRateSel}), 32'h4D);
      rd_chk(REG_OPT0, 16'hE139);
      battery_present_n = 1'b1;
      settle();
      check(32'(learnActive), 32'h0);
      rd_chk(REG_OPT0, 16'hE119);
      battery_present_n = 1'b0;
      batteryDepleted = 1'b1;
      settle();
      wr(REG_OPT0, 16'h0021);
      rd_chk(REG_OPT0, 16'h0001);
      batteryDepleted = 1'b0;
      // every legal rate code, watchdog off
      for (int r = 0; r < 3; r++) begin
         wr(REG_OPT0, 16'(r) << 8);
         check(32'(switchRateSel), 32'(r));
      end
      check(32'({adapterSenseGainSel, dischargeSenseGainSel}), 32'h0);
      wr(REG_ICHG, 16'hFFFF);
      wr(REG_VCHG, 16'h7FF0);
      check(32'({chargeEnable, chargeCurrentSet, chargeVoltageSet}), 32'h7FFFF);
      // another enabling condition dropping must stop charging on its own
      chargeConditionsOk = 1'b0;
      settle();
      check(32'(chargeEnable), 32'h0);
      chargeConditionsOk = 1'b1;
      rd_chk(REG_ICHG, 16'h1FC0);
      wr(REG_OPT0, 16'h0201);
      check(32'(chargeEnable), 32'h0);
      repeat (200) @(posedge sys_clk);
      #1 check(32'(watchdogExpired), 32'h0);
      // low power versus performance on battery only
      batteryOnly = 1'b1;
      wr(REG_OPT1, 16'hFFFF);
      rd_chk(REG_OPT1, 16'hFEFA);
      wr(REG_OPT0, 16'h8000);
      check(32'({lowPowerActive, processorHotAlertEn, dischargeMonitorEn, powerMonitorEn, comparatorEn}),
         32'h10);
      wr(REG_OPT0, 16'h0000);
      check(32'({lowPowerActive, processorHotAlertEn, dischargeMonitorEn, powerMonitorEn, comparatorEn}),
         32'h0F);
      batteryOnly = 1'b0;
      // 80-cycle period: expiry during the frame, a setting write revives it
      wr(REG_OPT0, 16'h6000);
      wr(REG_VCHG, 16'h7FF0);
      check(32'({watchdogExpired, converterEnable}), 32'h1);
      repeat (40) @(posedge sys_clk);
      #1 check(32'({watchdogExpired, converterEnable, chargeEnable}), 32'h4);
      wr(REG_ICHG, 16'h1FC0);
      check(32'({watchdogExpired, converterEnable, chargeEnable}), 32'h3);
      // a low clock enable freezes the count short of its period
      clkEn = 1'b0;
      repeat (100) @(posedge sys_clk);
      #1 check(32'(watchdogExpired), 32'h0);
      clkEn = 1'b1;
      // 20-cycle period: fresh service write, then expiry before the bench looks
      wr(REG_OPT0, 16'h2000);
      wr(REG_ICHG, 16'h1FC0);
      check(32'(watchdogExpired), 32'h1);
      // unknown command: write ignored, read gives zero
      wr(8'h55, 16'hFFFF);
      rd_chk(8'h55, 16'h0000);
      rd_chk(REG_OPT0, 16'h2000);
      finish_test();
   end
endmodule
